/* File: logic/gdr_pkg.sv */
// Constants shared by the gamma DAC register target and its two-wire controller.
// Assumes a single 100 MHz core clock on both ends.
// Notes on behaviour
// - Single failed stored bit is corrected on acquire
// - Two failed bits load mid-scale instead
// - Identity pointer returns fixed 16-bit code
// - Top two data bits select volatile or store
// - Volatile code is bits 9:8 plus low byte
// - Pointer bits 7:6 zero for volatile access
// - Ack pointers 0x00-0x17 and 0x3c-0x3f, store nine channels only
// - Unimplemented acked pointers read as zero
// - Channel changes only after both bytes
// - Every written data byte is acknowledged
// - First-stage write leaves output latch alone
// - Bit 15 set transfers first stage to outputs
// - Pointer advances after each completed pair
// - Sequential pairs reach common channel at 19th
// - Write-disable bit only by single write
// - Trailing partial pair is discarded
// - Reads need pointer write, restart, read address
// - Single reads cover channels and aux pointers
// - High byte first; channel bits 15:10 meaningless
// - Single read: ack first, end on second
// - Sequential read steps until nack or stop
// - Aux registers read only singly; sequential reads still step into and through them
package gdr_pkg;
  localparam int NCH = 9;
  localparam int CODE_W = 10;
  localparam int NV_W = 15;
  localparam logic [CODE_W-1:0] MID_CODE = 10'h200;
  localparam logic [5:0] PTR_COMMON_ELECTRODE_CHANNEL = 6'h12;
  localparam logic [5:0] PTR_ACK_LAST = 6'h17;
  localparam logic [5:0] PTR_AUX_FIRST = 6'h3c;
  localparam logic [5:0] PTR_REV = 6'h3c;
  localparam logic [5:0] PTR_ID = 6'h3d;
  localparam logic [5:0] PTR_WDIS = 6'h3e;
  localparam logic [5:0] PTR_WCNT = 6'h3f;
  localparam logic [1:0] PTR_VOL = 2'h0;
  localparam logic [1:0] NV_SEL = 2'h1;
  // Arbitrary values, not tied to any real part
  localparam logic [6:0] DEV_ADDR_DEF = 7'h4c;
  localparam logic [15:0] ID_CODE_DEF = 16'h5a3c;
  localparam logic [15:0] REV_CODE_DEF = 16'h0001;
  localparam int CLK_NS = 10;
  localparam int SCL_HALF_NS = 1250;
  localparam logic [7:0] SCL_HALF_CYC = 8'(SCL_HALF_NS / CLK_NS);
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [1:0] OP_START = 2'h0;
  localparam logic [1:0] OP_STOP = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
endpackage : gdr_pkg

/* File: logic/gdr_if.sv */
// Two-wire link between controller and target, open-drain with pull-ups.
// Assumes both ends drive low only, through their enables.
`timescale 1ns/10ps
interface gdr_if;
  logic scl_oe_ctl;
  logic sda_oe_ctl;
  logic sda_oe_dev;
  logic scl;
  logic sda;
  assign scl = ~scl_oe_ctl;
  assign sda = ~(sda_oe_ctl | sda_oe_dev);
  modport ctl (output scl_oe_ctl, output sda_oe_ctl, input scl, input sda);
  modport dev (output sda_oe_dev, input scl, input sda);
endinterface : gdr_if

/* File: logic/gdr_dev.sv */
// Target end: pointer, two-stage channel registers, reads and acquire correction.
// Assumes the link pins come from outside the core clock domain.
`timescale 1ns/10ps
module gdr_dev #(
  parameter logic [6:0] DEV_ADDR = gdr_pkg::DEV_ADDR_DEF,
  parameter logic [15:0] ID_CODE = gdr_pkg::ID_CODE_DEF,
  parameter logic [15:0] REV_CODE = gdr_pkg::REV_CODE_DEF
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  gdr_if.dev bus,
  input wire logic nv_load,
  input wire logic [3:0] nv_chan,
  input wire logic [gdr_pkg::NV_W-1:0] nv_word,
  input wire logic [3:0] wr_count,
  output logic [gdr_pkg::NCH-1:0][gdr_pkg::CODE_W-1:0] out_level,
  output logic write_disable
);
  import gdr_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_RACK = 5'h10
  } gdr_st_t;

  typedef enum logic [4:0] {
    PH_ADDR = 5'h01,
    PH_PTR = 5'h02,
    PH_HI = 5'h04,
    PH_LO = 5'h08,
    PH_RD = 5'h10
  } gdr_ph_t;

  // Extended Hamming word: positions 14..1, overall parity at bit 0
  function automatic logic [CODE_W-1:0] nv_fix(input logic [NV_W-1:0] cw);
    logic [3:0] syn;
    logic par;
    logic [NV_W-1:0] c;
    syn = 4'h0;
    par = ^cw;
    c = cw;
    for (int p = 1; p < NV_W; p++) begin
      if (cw[p]) begin
        syn = syn ^ 4'(p);
      end
    end
    if (par) begin
      c[syn] = ~c[syn];
    end
    if (!par && syn != 4'h0) begin
      nv_fix = MID_CODE;
    end else begin
      nv_fix = {c[14], c[13], c[12], c[11], c[10], c[9], c[7], c[6], c[5], c[3]};
    end
  endfunction : nv_fix

  // Valid flag above a 4-bit channel index
  function automatic logic [4:0] chan_of(input logic [5:0] p);
    if (p <= 6'h07) begin
      chan_of = {1'b1, p[3:0]};
    end else if (p == PTR_COMMON_ELECTRODE_CHANNEL) begin
      chan_of = {1'b1, 4'h8};
    end else begin
      chan_of = 5'h00;
    end
  endfunction : chan_of

  gdr_st_t state_reg, state_next;
  gdr_ph_t phase_reg, phase_next;
  logic [2:0] scl_sy_reg, scl_sy_next;
  logic [2:0] sda_sy_reg, sda_sy_next;
  logic scl_f_reg, scl_f_next;
  logic sda_f_reg, sda_f_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] hi_reg, hi_next;
  logic [5:0] ptr_reg, ptr_next;
  logic first_reg, first_next;
  logic tx_lo_reg, tx_lo_next;
  logic sda_oe_reg, sda_oe_next;
  logic wd_reg, wd_next;
  logic [NCH-1:0][CODE_W-1:0] stage_reg, stage_next;
  logic [NCH-1:0][CODE_W-1:0] latch_reg, latch_next;
  logic rise, fall, start_ev, stop_ev;
  logic [15:0] word_cur, word_inc;
  logic [4:0] ch;

  assign bus.sda_oe_dev = sda_oe_reg;
  assign out_level = latch_reg;
  assign write_disable = wd_reg;

  // Read mux; gaps return zero
  function automatic logic [15:0] rd_word(input logic [5:0] p,
                                          input logic [NCH-1:0][CODE_W-1:0] st,
                                          input logic wd,
                                          input logic [3:0] wc);
    logic [4:0] c;
    c = chan_of(p);
    if (c[4]) begin
      rd_word = {6'h00, st[c[3:0]]};
    end else if (p == PTR_REV) begin
      rd_word = REV_CODE;
    end else if (p == PTR_ID) begin
      rd_word = ID_CODE;
    end else if (p == PTR_WDIS) begin
      rd_word = {15'h0000, wd};
    end else if (p == PTR_WCNT) begin
      rd_word = {12'h000, wc};
    end else begin
      rd_word = 16'h0000;
    end
  endfunction : rd_word

  always_comb begin
    sda_sy_next = {sda_sy_reg[1:0], bus.sda};
    scl_sy_next = {scl_sy_reg[1:0], bus.scl};
    scl_f_next = (scl_sy_reg[1] == scl_sy_reg[2]) ? scl_sy_reg[2] : scl_f_reg;
    sda_f_next = (sda_sy_reg[1] == sda_sy_reg[2]) ? sda_sy_reg[2] : sda_f_reg;
    rise = scl_f_next & ~scl_f_reg;
    fall = ~scl_f_next & scl_f_reg;
    start_ev = scl_f_reg & scl_f_next & sda_f_reg & ~sda_f_next;
    stop_ev = scl_f_reg & scl_f_next & ~sda_f_reg & sda_f_next;
  end

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    hi_next = hi_reg;
    ptr_next = ptr_reg;
    first_next = first_reg;
    tx_lo_next = tx_lo_reg;
    sda_oe_next = sda_oe_reg;
    wd_next = wd_reg;
    stage_next = stage_reg;
    latch_next = latch_reg;
    word_cur = rd_word(ptr_reg, stage_reg, wd_reg, wr_count);
    word_inc = rd_word(6'(ptr_reg + 6'h01), stage_reg, wd_reg, wr_count);
    ch = chan_of(ptr_reg);
    // Acquire updates both stages at once
    if (nv_load && nv_chan < 4'(NCH)) begin
      stage_next[nv_chan] = nv_fix(nv_word);
      latch_next[nv_chan] = nv_fix(nv_word);
    end
    if (start_ev) begin
      // A restart drops any half pair still in hi_reg
      state_next = ST_RX;
      phase_next = PH_ADDR;
      cnt_next = 4'h0;
      sda_oe_next = 1'b0;
    end else if (stop_ev) begin
      state_next = ST_IDLE;
      sda_oe_next = 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
        end
        ST_RX: begin
          if (rise) begin
            sh_next = {sh_reg[6:0], sda_f_next};
            cnt_next = cnt_reg + 4'h1;
          end else if (fall && cnt_reg == 4'h8) begin
            cnt_next = 4'h0;
            state_next = ST_ACK;
            sda_oe_next = 1'b1;
            case (phase_reg)
              PH_ADDR: begin
                if (sh_reg[7:1] != DEV_ADDR) begin
                  state_next = ST_IDLE;
                  sda_oe_next = 1'b0;
                end else if (sh_reg[0]) begin
                  phase_next = PH_RD;
                end else begin
                  phase_next = PH_PTR;
                end
              end
              PH_PTR: begin
                // Other pointer forms belong to acquire commands, not served here
                if (sh_reg[7:6] == PTR_VOL &&
                    (sh_reg[5:0] <= PTR_ACK_LAST || sh_reg[5:0] >= PTR_AUX_FIRST)) begin
                  ptr_next = sh_reg[5:0];
                  first_next = 1'b1;
                  phase_next = PH_HI;
                end else begin
                  state_next = ST_IDLE;
                  sda_oe_next = 1'b0;
                end
              end
              PH_HI: begin
                hi_next = sh_reg;
                phase_next = PH_LO;
              end
              PH_LO: begin
                phase_next = PH_HI;
                ptr_next = ptr_reg + 6'h01;
                first_next = 1'b0;
                // Store writes are acknowledged and dropped here
                if (hi_reg[7:6] != NV_SEL) begin
                  if (first_reg && ptr_reg == PTR_WDIS) begin
                    wd_next = sh_reg[0];
                  end else if (ch[4]) begin
                    stage_next[ch[3:0]] = {hi_reg[1:0], sh_reg};
                  end
                  if (hi_reg[7]) begin
                    latch_next = stage_next;
                  end
                end
              end
              default: begin
              end
            endcase
          end
        end
        ST_ACK: begin
          if (fall) begin
            sda_oe_next = 1'b0;
            state_next = ST_RX;
            if (phase_reg == PH_RD) begin
              state_next = ST_TX;
              sh_next = word_cur[15:8];
              sda_oe_next = ~word_cur[15];
              tx_lo_next = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (fall) begin
            if (cnt_reg == 4'h8) begin
              cnt_next = 4'h0;
              sda_oe_next = 1'b0;
              state_next = ST_RACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              sda_oe_next = ~sh_reg[6];
            end
          end
        end
        ST_RACK: begin
          if (rise && sda_f_next) begin
            state_next = ST_IDLE;
          end else if (fall) begin
            state_next = ST_TX;
            if (!tx_lo_reg) begin
              sh_next = word_cur[7:0];
              sda_oe_next = ~word_cur[7];
              tx_lo_next = 1'b1;
            end else begin
              ptr_next = ptr_reg + 6'h01;
              sh_next = word_inc[15:8];
              sda_oe_next = ~word_inc[15];
              tx_lo_next = 1'b0;
            end
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_ADDR;
      scl_sy_reg <= 3'h7;
      sda_sy_reg <= 3'h7;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      hi_reg <= 8'h00;
      ptr_reg <= 6'h00;
      first_reg <= 1'b0;
      tx_lo_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      wd_reg <= 1'b0;
      stage_reg <= {NCH{MID_CODE}};
      latch_reg <= {NCH{MID_CODE}};
    end else if (clk_en) begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      scl_sy_reg <= scl_sy_next;
      sda_sy_reg <= sda_sy_next;
      scl_f_reg <= scl_f_next;
      sda_f_reg <= sda_f_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      hi_reg <= hi_next;
      ptr_reg <= ptr_next;
      first_reg <= first_next;
      tx_lo_reg <= tx_lo_next;
      sda_oe_reg <= sda_oe_next;
      wd_reg <= wd_next;
      stage_reg <= stage_next;
      latch_reg <= latch_next;
    end
  end
endmodule : gdr_dev

/* File: logic/gdr_ctl.sv */
// Controller end: APB command/status registers driving bus-level primitives.
// Assumes software composes transfers from start, byte and stop steps.
`timescale 1ns/10ps
module gdr_ctl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  gdr_if.ctl bus
);
  import gdr_pkg::*;

  typedef enum logic [3:0] {
    C_IDLE = 4'h1,
    C_START = 4'h2,
    C_BIT = 4'h4,
    C_STOP = 4'h8
  } gdr_cst_t;

  gdr_cst_t state_reg, state_next;
  logic [1:0] step_reg, step_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] div_reg, div_next;
  logic [8:0] tx_reg, tx_next;
  logic [7:0] rx_reg, rx_next;
  logic ack_reg, ack_next;
  logic scl_oe_reg, scl_oe_next;
  logic sda_oe_reg, sda_oe_next;
  logic [2:0] sda_sy_reg, sda_sy_next;
  logic sda_f_reg, sda_f_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic tick, cmd_wr;

  assign bus.scl_oe_ctl = scl_oe_reg;
  assign bus.sda_oe_ctl = sda_oe_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  always_comb begin
    sda_sy_next = {sda_sy_reg[1:0], bus.sda};
    sda_f_next = (sda_sy_reg[1] == sda_sy_reg[2]) ? sda_sy_reg[2] : sda_f_reg;
    // One wait-free answer: pready rises in the first access cycle
    pready_next = psel & ~penable;
    prdata_next = 32'h0000_0000;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      if (paddr == REG_STAT) begin
        prdata_next = {16'h0000, rx_reg, 6'h00, ack_reg, state_reg != C_IDLE};
      end else if (paddr != REG_CMD) begin
        pslverr_next = 1'b1;
      end
    end
    cmd_wr = psel & penable & pready_reg & pwrite & (paddr == REG_CMD);
  end

  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    ack_next = ack_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    tick = (div_reg == SCL_HALF_CYC - 8'h01);
    div_next = (state_reg == C_IDLE || tick) ? 8'h00 : div_reg + 8'h01;
    case (state_reg)
      C_IDLE: begin
        // Commands while busy are ignored
        if (cmd_wr) begin
          step_next = 2'h0;
          bit_next = 4'h0;
          case (pwdata[1:0])
            OP_START: begin
              state_next = C_START;
              sda_oe_next = 1'b0;
            end
            OP_STOP: begin
              state_next = C_STOP;
              sda_oe_next = 1'b1;
            end
            OP_WRITE: begin
              state_next = C_BIT;
              tx_next = {pwdata[15:8], 1'b1};
              sda_oe_next = ~pwdata[15];
            end
            default: begin
              state_next = C_BIT;
              tx_next = {8'hff, ~pwdata[16]};
              sda_oe_next = 1'b0;
            end
          endcase
        end
      end
      C_START: begin
        if (tick) begin
          step_next = step_reg + 2'h1;
          case (step_reg)
            2'h0: scl_oe_next = 1'b0;
            2'h1: sda_oe_next = 1'b1;
            2'h2: scl_oe_next = 1'b1;
            default: state_next = C_IDLE;
          endcase
        end
      end
      C_BIT: begin
        // Data moves one cycle after the clock falls, except the release that ends the ninth bit, which moves with it
        if (step_reg == 2'h2) begin
          step_next = 2'h0;
          sda_oe_next = ~tx_reg[8];
        end else if (tick && step_reg == 2'h0) begin
          step_next = 2'h1;
          scl_oe_next = 1'b0;
        end else if (tick) begin
          scl_oe_next = 1'b1;
          if (bit_reg == 4'h8) begin
            ack_next = ~sda_f_reg;
            sda_oe_next = 1'b0;
            state_next = C_IDLE;
          end else begin
            rx_next = {rx_reg[6:0], sda_f_reg};
            bit_next = bit_reg + 4'h1;
            tx_next = {tx_reg[7:0], 1'b1};
            step_next = 2'h2;
          end
        end
      end
      C_STOP: begin
        if (tick) begin
          step_next = step_reg + 2'h1;
          case (step_reg)
            2'h0: scl_oe_next = 1'b0;
            2'h1: sda_oe_next = 1'b0;
            default: state_next = C_IDLE;
          endcase
        end
      end
      default: state_next = C_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= C_IDLE;
      step_reg <= 2'h0;
      bit_reg <= 4'h0;
      div_reg <= 8'h00;
      tx_reg <= 9'h1ff;
      rx_reg <= 8'h00;
      ack_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      sda_sy_reg <= 3'h7;
      sda_f_reg <= 1'b1;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      step_reg <= step_next;
      bit_reg <= bit_next;
      div_reg <= div_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      ack_reg <= ack_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      sda_sy_reg <= sda_sy_next;
      sda_f_reg <= sda_f_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end
endmodule : gdr_ctl

/* File: verification/gdr_link_monitor.sv */
// Concurrent checks on the two-wire link between controller and target.
// Assumes the interface resolves the open-drain wires from both enables.
`timescale 1ns/10ps
module gdr_link_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_oe_ctl,
  input wire logic sda_oe_ctl,
  input wire logic sda_oe_dev,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence start_seen;
    scl && $past(scl) && $fell(sda);
  endsequence

  sequence stop_seen;
    scl && $past(scl) && $rose(sda);
  endsequence

  a_free_after_reset: assert property ($rose(rst_n) |-> !scl_oe_ctl && !sda_oe_ctl && !sda_oe_dev)
    else $error("link not released after reset");
  a_dev_moves_low: assert property ($changed(sda_oe_dev) |-> !scl)
    else $error("target moved data while clock high");
  a_dev_after_fall: assert property ($changed(sda_oe_dev) |-> !$past(scl, 2))
    else $error("target moved data too soon after clock fall");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  a_start_clocks: assert property (start_seen |-> ##[1:1000] !scl)
    else $error("no clock after start");
  // A stop must leave the bus idle, target released
  a_stop_idle: assert property (stop_seen |-> (scl && sda && !sda_oe_dev) [*4])
    else $error("bus not idle after stop");
  a_dev_bit_clocked: assert property ($rose(sda_oe_dev) |-> ##[1:400] $rose(scl))
    else $error("target drive not clocked");
endmodule : gdr_link_monitor

/* File: verification/testbench.sv */
// Bench: APB drives the controller, which talks to the target over the link.
// Assumes one 100 MHz clock; byte time is long, so scenarios stay short.
`timescale 1ns/10ps
`define CHK(a, b) begin \
  checks_done++; \
  if ((a) !== (b)) begin \
    n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); \
  end \
end
module testbench;
  import gdr_pkg::*;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, nv_load, perr, write_disable;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, st;
  logic [3:0] nv_chan, wr_count;
  logic [NV_W-1:0] nv_word, w;
  logic [CODE_W-1:0] d;
  logic [NCH-1:0][CODE_W-1:0] out_level;
  logic [CODE_W-1:0] stg [NCH];
  logic [CODE_W-1:0] outv [NCH];
  int n_errors, checks_done, j;
  gdr_if lnk();
  gdr_ctl gdr_ctl_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(lnk));
  gdr_dev gdr_dev_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .bus(lnk), .nv_load(nv_load),
    .nv_chan(nv_chan), .nv_word(nv_word), .wr_count(wr_count), .out_level(out_level), .write_disable(write_disable));
  gdr_link_monitor mon (.core_clk(core_clk), .rst_n(rst_n), .scl_oe_ctl(lnk.scl_oe_ctl),
    .sda_oe_ctl(lnk.sda_oe_ctl), .sda_oe_dev(lnk.sda_oe_dev), .scl(lnk.scl), .sda(lnk.sda));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task results;
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  task tend(input string s);
    $display("test %s ended, %0d checks, %0d mismatches", s, checks_done, n_errors);
  endtask : tend

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    int i;
    i = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      n_errors++;
      results();
    end
  endtask : apb

  // Busy is polled over APB; a byte takes about 2300 cycles
  task op(input logic [1:0] o, input logic [7:0] b, input logic ack);
    int i;
    i = 0;
    apb(1'b1, REG_CMD, {15'h0, ack, b, 6'h0, o});
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      i++;
    end while (rd[0] !== 1'b0 && i < 2000);
    st = rd;
    if (i >= 2000) begin
      n_errors++;
      results();
    end
  endtask : op

  task wb(input logic [7:0] b, input logic ack);
    op(OP_WRITE, b, 1'b0);
    `CHK(st[1], ack)
  endtask : wb

  function automatic int ci(input logic [5:0] p);
    if (p < 6'h08) return int'(p);
    return (p == PTR_COMMON_ELECTRODE_CHANNEL) ? 8 : 9;
  endfunction : ci

  task pair(input logic [5:0] p, input logic [7:0] hi, input logic [7:0] lo);
    wb(hi, 1'b1);
    wb(lo, 1'b1);
    if (ci(p) < 9 && hi[7:6] != NV_SEL) stg[ci(p)] = {hi[1:0], lo};
    if (hi[7]) outv = stg;
  endtask : pair

  task addr(input logic [5:0] p, input logic rd_too);
    op(OP_START, 8'h00, 1'b0);
    wb({DEV_ADDR_DEF, 1'b0}, 1'b1);
    wb({2'b00, p}, 1'b1);
    if (rd_too) begin
      op(OP_START, 8'h00, 1'b0);
      wb({DEV_ADDR_DEF, 1'b1}, 1'b1);
    end
  endtask : addr

  task rword(input logic [15:0] e, input logic last, input logic full);
    logic [15:0] v;
    op(OP_READ, 8'h00, 1'b1);
    v[15:8] = st[15:8];
    op(OP_READ, 8'h00, !last);
    v[7:0] = st[15:8];
    if (full) `CHK(v, e)
    else `CHK(v[9:0], e[9:0])
  endtask : rword

  task chk_out;
    for (int c = 0; c < NCH; c++) `CHK(out_level[c], outv[c])
  endtask : chk_out

  // Extended Hamming: parity at positions 1,2,4,8 and overall even parity at bit 0
  function automatic logic [NV_W-1:0] enc(input logic [CODE_W-1:0] v);
    logic [NV_W-1:0] r;
    int pos [10] = '{14, 13, 12, 11, 10, 9, 7, 6, 5, 3};
    r = '0;
    for (int k = 0; k < 10; k++) r[pos[k]] = v[9 - k];
    for (int p = 1; p < 16; p = p * 2) begin
      for (int i = 1; i < 15; i++) begin
        if ((i & p) != 0 && i != p) r[p] = r[p] ^ r[i];
      end
    end
    r[0] = ^r[14:1];
    return r;
  endfunction : enc

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nv_load = 1'b0;
    nv_chan = 4'h0;
    nv_word = '0;
    n_errors = 0;
    checks_done = 0;
    rd = $urandom(32'hfce6);
    wr_count = 4'($urandom());
    for (int c = 0; c < NCH; c++) begin
      stg[c] = MID_CODE;
      outv[c] = MID_CODE;
    end
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    chk_out();
    // Odd channels get two flipped bits, even ones a single flip
    for (int c = 0; c < NCH; c++) begin
      d = CODE_W'($urandom());
      j = $urandom_range(14, 0);
      w = enc(d) ^ (15'h1 << j);
      if (c % 2 == 1) w = w ^ (15'h1 << ((j + 1) % 15));
      @(posedge core_clk);
      nv_load <= 1'b1;
      nv_chan <= 4'(c);
      nv_word <= w;
      @(posedge core_clk);
      nv_load <= 1'b0;
      @(posedge core_clk);
      stg[c] = (c % 2 == 1) ? MID_CODE : d;
      outv[c] = stg[c];
      `CHK(out_level[c], outv[c])
    end
    tend("acquire");
    apb(1'b0, 8'h08, 32'h0);
    `CHK({perr, rd}, {1'b1, 32'h0})
    // Pair at 0x06, then a lone first byte with the update bit for 0x07
    addr(6'h06, 1'b0);
    pair(6'h06, {2'b00, 6'($urandom())}, 8'($urandom()));
    wb({1'b1, 7'($urandom())}, 1'b1);
    op(OP_STOP, 8'h00, 1'b0);
    chk_out();
    tend("partial pair");
    addr(6'h11, 1'b0);
    for (int k = 0; k < 3; k++) pair(6'h11 + 6'(k), {k == 1, 1'b0, 6'($urandom())}, 8'($urandom()));
    op(OP_STOP, 8'h00, 1'b0);
    chk_out();
    tend("sequential write");
    addr(6'h06, 1'b0);
    pair(6'h06, {2'b01, 6'($urandom())}, 8'($urandom()));
    op(OP_STOP, 8'h00, 1'b0);
    addr(6'h06, 1'b1);
    rword({6'h0, stg[6]}, 1'b0, 1'b0);
    rword({6'h0, stg[7]}, 1'b0, 1'b0);
    rword(16'h0000, 1'b1, 1'b1);
    op(OP_STOP, 8'h00, 1'b0);
    tend("sequential read");
    addr(PTR_ID, 1'b1);
    rword(ID_CODE_DEF, 1'b1, 1'b1);
    op(OP_STOP, 8'h00, 1'b0);
    tend("identity");
    op(OP_START, 8'h00, 1'b0);
    wb({DEV_ADDR_DEF ^ 7'h01, 1'b0}, 1'b0);
    op(OP_STOP, 8'h00, 1'b0);
    for (int k = 0; k < 2; k++) begin
      op(OP_START, 8'h00, 1'b0);
      wb({DEV_ADDR_DEF, 1'b0}, 1'b1);
      wb(k == 0 ? 8'h40 : 8'h18, 1'b0);
      op(OP_STOP, 8'h00, 1'b0);
    end
    tend("refusals");
    addr(PTR_WDIS, 1'b0);
    pair(PTR_WDIS, 8'h00, 8'h01);
    op(OP_STOP, 8'h00, 1'b0);
    `CHK(write_disable, 1'b1)
    chk_out();
    tend("write disable");
    results();
  end
endmodule : testbench
